// *** core/pfs_regs.svh ***
`ifndef PFS_REGS_SVH
`define PFS_REGS_SVH

// Register indices; the byte address of each is four times its index
`define PFS_IDX_LOSS_ACT   14'h0D19
`define PFS_IDX_LOSS_TIME  14'h0D1A
`define PFS_IDX_LOSS_UPPER 14'h0D1B
`define PFS_IDX_LOSS_LOWER 14'h0D1C
`define PFS_IDX_SLP_EN     14'h0D1D
`define PFS_IDX_SLP_FREQ   14'h0D1E
`define PFS_IDX_SLP_DLY    14'h0D1F
`define PFS_IDX_WAKE_DEV   14'h0D20
`define PFS_IDX_WAKE_DLY   14'h0D21
`define PFS_IDX_STATUS     14'h0D22

// Reset values (times in 0.1 s, levels in 0.1 %, frequency in 0.01 Hz)
`define PFS_RST_LOSS_ACT   16'h0000
`define PFS_RST_LOSS_TIME  16'h000A
`define PFS_RST_LOSS_UPPER 16'h03E8
`define PFS_RST_LOSS_LOWER 16'h0000
`define PFS_RST_SLP_EN     16'h0000
`define PFS_RST_SLP_FREQ   16'h03E8
`define PFS_RST_SLP_DLY    16'h0258
`define PFS_RST_WAKE_DEV   16'h0032
`define PFS_RST_WAKE_DLY   16'h000A

// Largest legal value of each setting except the sleep frequency, whose bound is the maximum output frequency input
`define PFS_MAX_LOSS_ACT   16'h0003
`define PFS_MAX_LOSS_TIME  16'h04B0
`define PFS_MAX_PCT        16'h03E8
`define PFS_MAX_SLP_EN     16'h0001
`define PFS_MAX_SLP_DLY    16'h8CA0
`define PFS_MAX_WAKE_DEV   16'h01F4
`define PFS_MAX_WAKE_DLY   16'h0258

// Status register bits
`define PFS_ST_FAULT 0
`define PFS_ST_WARN  1
`define PFS_ST_HOLD  2
`define PFS_ST_DECEL 3
`define PFS_ST_SLEEP 4
`define PFS_ST_ARMED 5

// Time base: 0.1 s tick from a 50 ns clock
`define PFS_TICK_NS 100000000
`define PFS_CLK_NS  50

// Bus responses
`define PFS_RESP_OKAY   2'h0
`define PFS_RESP_SLVERR 2'h2

`endif

// *** core/pfs_pkg.sv ***
package pfs_pkg;

	// Setting word, feedback and frequency values
	typedef logic [15:0] pfs_word_t;

	// Action on feedback loss
	typedef enum logic [1:0] {
		PFS_ACT_NONE,
		PFS_ACT_STOP,
		PFS_ACT_WARN,
		PFS_ACT_HOLD
	} pfs_loss_act_e;

	// Sleep sequence states
	typedef enum logic [1:0] {
		PFS_AWAKE,
		PFS_DECEL,
		PFS_ASLEEP
	} pfs_sleep_e;

endpackage

// *** core/pfs_supervisor.sv ***
`timescale 1ns/1ps
`include "pfs_regs.svh"
module pfs_supervisor #(
	parameter int AW          = 16,
	parameter int TICK_CYCLES = `PFS_TICK_NS / `PFS_CLK_NS
) (
	input  wire                 i_mclk,
	input  wire                 i_rst_n,
	input  wire                 i_awvalid,
	output logic                o_awready,
	input  wire  [AW-1:0]       i_awaddr,
	input  wire                 i_wvalid,
	output logic                o_wready,
	input  wire  [31:0]         i_wdata,
	input  wire  [3:0]          i_wstrb,
	output logic                o_bvalid,
	input  wire                 i_bready,
	output logic [1:0]          o_bresp,
	input  wire                 i_arvalid,
	output logic                o_arready,
	input  wire  [AW-1:0]       i_araddr,
	output logic                o_rvalid,
	input  wire                 i_rready,
	output logic [31:0]         o_rdata,
	output logic [1:0]          o_rresp,
	input  wire                 i_running,
	input  wire                 i_pid_source,
	input  wire                 i_negative_char,
	input  wire  pfs_pkg::pfs_word_t i_feedback,
	input  wire  pfs_pkg::pfs_word_t i_setpoint,
	input  wire  pfs_pkg::pfs_word_t i_pid_freq,
	input  wire  pfs_pkg::pfs_word_t i_maximum_output_frequency,
	input  wire                 i_out_zero,
	output logic                o_output_block,
	output logic                o_sleep_decel,
	output logic                o_sleeping,
	output logic                o_feedback_loss_fault,
	output logic                o_feedback_loss_warning,
	output logic                o_freq_hold,
	output pfs_pkg::pfs_word_t  o_held_freq
);
	import pfs_pkg::*;

	localparam int SL_ACT   = 0;
	localparam int SL_TIME  = `PFS_IDX_LOSS_TIME - `PFS_IDX_LOSS_ACT;
	localparam int SL_UPPER = `PFS_IDX_LOSS_UPPER - `PFS_IDX_LOSS_ACT;
	localparam int SL_LOWER = `PFS_IDX_LOSS_LOWER - `PFS_IDX_LOSS_ACT;
	localparam int SL_SLPEN = `PFS_IDX_SLP_EN - `PFS_IDX_LOSS_ACT;
	localparam int SL_SFREQ = `PFS_IDX_SLP_FREQ - `PFS_IDX_LOSS_ACT;
	localparam int SL_SDLY  = `PFS_IDX_SLP_DLY - `PFS_IDX_LOSS_ACT;
	localparam int SL_WDEV  = `PFS_IDX_WAKE_DEV - `PFS_IDX_LOSS_ACT;
	localparam int SL_WDLY  = `PFS_IDX_WAKE_DLY - `PFS_IDX_LOSS_ACT;
	localparam int SL_STAT  = `PFS_IDX_STATUS - `PFS_IDX_LOSS_ACT;
	localparam int TW       = $clog2(TICK_CYCLES + 1);

	// Maps a byte address to a register slot, 4'hF when unmapped
	function automatic logic [3:0] slot_of(input logic [AW-1:0] a);
		logic [13:0] idx;
		idx = 14'(a >> 2);
		if (idx >= `PFS_IDX_LOSS_ACT && idx <= `PFS_IDX_STATUS) begin
			slot_of = 4'(idx - `PFS_IDX_LOSS_ACT);
		end else begin
			slot_of = 4'hF;
		end
	endfunction

	// Reset value of each setting
	function automatic pfs_word_t rst_of(input int s);
		case (s)
			SL_ACT:   rst_of = `PFS_RST_LOSS_ACT;
			SL_TIME:  rst_of = `PFS_RST_LOSS_TIME;
			SL_UPPER: rst_of = `PFS_RST_LOSS_UPPER;
			SL_LOWER: rst_of = `PFS_RST_LOSS_LOWER;
			SL_SLPEN: rst_of = `PFS_RST_SLP_EN;
			SL_SFREQ: rst_of = `PFS_RST_SLP_FREQ;
			SL_SDLY:  rst_of = `PFS_RST_SLP_DLY;
			SL_WDEV:  rst_of = `PFS_RST_WAKE_DEV;
			default:  rst_of = `PFS_RST_WAKE_DLY;
		endcase
	endfunction

	// Largest value a setting accepts; writes above it are dropped
	function automatic pfs_word_t max_of(input logic [3:0] s, input pfs_word_t fmax);
		case (s)
			4'(SL_ACT):   max_of = `PFS_MAX_LOSS_ACT;
			4'(SL_TIME):  max_of = `PFS_MAX_LOSS_TIME;
			4'(SL_UPPER): max_of = `PFS_MAX_PCT;
			4'(SL_LOWER): max_of = `PFS_MAX_PCT;
			4'(SL_SLPEN): max_of = `PFS_MAX_SLP_EN;
			4'(SL_SFREQ): max_of = fmax;
			4'(SL_SDLY):  max_of = `PFS_MAX_SLP_DLY;
			4'(SL_WDEV):  max_of = `PFS_MAX_WAKE_DEV;
			default:      max_of = `PFS_MAX_WAKE_DLY;
		endcase
	endfunction

	pfs_word_t     cfg [0:8];
	logic [AW-1:0] aw_addr;
	logic [31:0]   w_data;
	logic [3:0]    w_strb;
	logic [3:0]    wr_slot;
	logic [3:0]    rd_slot;
	pfs_word_t     wr_val;
	pfs_word_t     rd_word;
	pfs_word_t     status;
	logic          wr_fire;
	logic          wr_legal;
	logic          st_clr;
	logic [TW-1:0] tick_cnt;
	logic          tick;
	logic [2:0]    tmr_cond;
	logic [2:0]    tmr_done;
	pfs_word_t     tmr_lim [0:2];
	pfs_word_t     tmr_cnt [0:2];
	pfs_loss_act_e act;
	logic          sleep_en;
	logic          loss_cond;
	logic          loss_done;
	logic [16:0]   fb_plus_dev;
	logic [16:0]   sp_plus_dev;
	logic          wake_dev_ok;
	logic          past_sp;
	pfs_sleep_e    state;
	pfs_sleep_e    next_state;
	logic          armed;
	logic          next_armed;
	logic          next_fault;
	logic          next_warn;
	logic          next_hold;

	// Write decode: both address and data held, no answer pending
	assign wr_fire  = !o_awready && !o_wready && !o_bvalid;
	assign wr_slot  = slot_of(aw_addr);
	assign wr_val   = {w_strb[1] ? w_data[15:8] : 8'h00, w_strb[0] ? w_data[7:0] : 8'h00};
	assign wr_legal = (wr_slot <= 4'(SL_WDLY)) && (&w_strb[1:0])
		&& (wr_val <= max_of(wr_slot, i_maximum_output_frequency));
	assign st_clr   = wr_fire && (wr_slot == 4'(SL_STAT)) && w_strb[0]
		&& w_data[`PFS_ST_FAULT];

	// Read decode and status word
	assign rd_slot = slot_of(i_araddr);
	assign status  = {10'h000, armed, o_sleeping, o_sleep_decel, o_freq_hold,
		o_feedback_loss_warning, o_feedback_loss_fault};
	assign rd_word = (rd_slot == 4'(SL_STAT)) ? status :
		(rd_slot <= 4'(SL_WDLY)) ? cfg[rd_slot] : 16'h0000;

	// Settings with documented defaults and ranges
	for (genvar g = 0; g <= SL_WDLY; g++) begin : g_cfg
		always_ff @(posedge i_mclk) begin
			if (!i_rst_n) begin
				cfg[g] <= rst_of(g);
			end else if (wr_fire && wr_legal && wr_slot == 4'(g)) begin
				cfg[g] <= wr_val;
			end
		end
	end

	// Write address, data and response channels
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_awready <= 1'b1;
			o_wready  <= 1'b1;
			o_bvalid  <= 1'b0;
			o_bresp   <= `PFS_RESP_OKAY;
			aw_addr   <= '0;
			w_data    <= 32'h00000000;
			w_strb    <= 4'h0;
		end else begin
			if (i_awvalid && o_awready) begin
				o_awready <= 1'b0;
				aw_addr   <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				o_wready <= 1'b0;
				w_data   <= i_wdata;
				w_strb   <= i_wstrb;
			end
			if (wr_fire) begin
				o_bvalid <= 1'b1;
				o_bresp  <= (wr_slot == 4'hF) ? `PFS_RESP_SLVERR : `PFS_RESP_OKAY;
			end else if (o_bvalid && i_bready) begin
				o_bvalid  <= 1'b0;
				o_awready <= 1'b1;
				o_wready  <= 1'b1;
			end
		end
	end

	// Read address and data channels
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h00000000;
			o_rresp   <= `PFS_RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b1;
			o_rdata   <= {16'h0000, rd_word};
			o_rresp   <= (rd_slot == 4'hF) ? `PFS_RESP_SLVERR : `PFS_RESP_OKAY;
		end else if (o_rvalid && i_rready) begin
			o_rvalid  <= 1'b0;
			o_arready <= 1'b1;
		end
	end

	// 0.1 s time base
	assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n || tick) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
		end
	end

	// Qualification timers: 0 loss, 1 sleep entry, 2 wake
	assign tmr_lim[0] = cfg[SL_TIME];
	assign tmr_lim[1] = cfg[SL_SDLY];
	assign tmr_lim[2] = cfg[SL_WDLY];
	for (genvar t = 0; t < 3; t++) begin : g_tmr
		assign tmr_done[t] = tmr_cond[t] && (tmr_cnt[t] >= tmr_lim[t]);
		always_ff @(posedge i_mclk) begin
			if (!i_rst_n || !tmr_cond[t]) begin
				tmr_cnt[t] <= 16'h0000;
			end else if (tick && tmr_cnt[t] < tmr_lim[t]) begin
				tmr_cnt[t] <= tmr_cnt[t] + 16'h0001;
			end
		end
	end

	// Feedback loss detection and action
	assign act       = pfs_loss_act_e'(cfg[SL_ACT][1:0]);
	assign loss_cond = (act != PFS_ACT_NONE) && i_running && i_pid_source
		&& (i_feedback > cfg[SL_UPPER] || i_feedback < cfg[SL_LOWER]);
	assign tmr_cond[0] = loss_cond;
	assign loss_done   = tmr_done[0];
	assign next_fault  = (loss_done && act == PFS_ACT_STOP)
		|| (o_feedback_loss_fault && !st_clr);
	assign next_warn   = loss_done && (act == PFS_ACT_WARN || act == PFS_ACT_HOLD);
	assign next_hold   = loss_done && (act == PFS_ACT_HOLD);

	// Sleep entry and wake conditions
	assign sleep_en    = cfg[SL_SLPEN][0];
	assign fb_plus_dev = {1'b0, i_feedback} + {1'b0, cfg[SL_WDEV]};
	assign sp_plus_dev = {1'b0, i_setpoint} + {1'b0, cfg[SL_WDEV]};
	assign wake_dev_ok = i_negative_char ? (sp_plus_dev < {1'b0, i_feedback})
		: ({1'b0, i_setpoint} > fb_plus_dev);
	assign past_sp     = i_negative_char ? (i_feedback < i_setpoint)
		: (i_feedback > i_setpoint);
	assign tmr_cond[1] = sleep_en && armed && state == PFS_AWAKE && i_running
		&& i_pid_source && (i_pid_freq < cfg[SL_SFREQ]);
	assign tmr_cond[2] = sleep_en && state != PFS_AWAKE && wake_dev_ok;
	assign next_armed  = sleep_en && state == PFS_AWAKE && (armed || past_sp);

	// Next sleep state
	always_comb begin
		next_state = state;
		unique case (state)
			PFS_AWAKE: begin
				if (tmr_done[1]) begin
					next_state = PFS_DECEL;
				end
			end
			PFS_DECEL: begin
				if (!sleep_en || tmr_done[2]) begin
					next_state = PFS_AWAKE;
				end else if (i_out_zero) begin
					next_state = PFS_ASLEEP;
				end
			end
			default: begin
				if (!sleep_en || tmr_done[2]) begin
					next_state = PFS_AWAKE;
				end
			end
		endcase
	end

	// Sleep state and registered outputs
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state                   <= PFS_AWAKE;
			armed                   <= 1'b0;
			o_feedback_loss_fault   <= 1'b0;
			o_feedback_loss_warning <= 1'b0;
			o_freq_hold             <= 1'b0;
			o_held_freq             <= 16'h0000;
			o_sleep_decel           <= 1'b0;
			o_sleeping              <= 1'b0;
			o_output_block          <= 1'b0;
		end else begin
			state                   <= next_state;
			armed                   <= next_armed;
			o_feedback_loss_fault   <= next_fault;
			o_feedback_loss_warning <= next_warn;
			o_freq_hold             <= next_hold;
			o_held_freq             <= o_freq_hold ? o_held_freq : i_pid_freq;
			o_sleep_decel           <= (next_state == PFS_DECEL);
			o_sleeping              <= (next_state == PFS_ASLEEP);
			o_output_block          <= next_fault || next_state == PFS_ASLEEP;
		end
	end

	// Checks
	property p_loss_off;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(act == PFS_ACT_NONE) |=> !o_feedback_loss_warning && !o_freq_hold;
	endproperty
	a_loss_off: assert property (p_loss_off) else $error("warning with action off");

	property p_need_run;
		@(posedge i_mclk) disable iff (!i_rst_n)
		!(i_running && i_pid_source) |=> !o_feedback_loss_warning && !o_freq_hold;
	endproperty
	a_need_run: assert property (p_need_run) else $error("loss flagged off PID");

	property p_stop;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(loss_done && act == PFS_ACT_STOP) |=> o_feedback_loss_fault && o_output_block;
	endproperty
	a_stop: assert property (p_stop) else $error("stop action missed");

	property p_warn;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(loss_done && act == PFS_ACT_WARN) |=> o_feedback_loss_warning && !o_freq_hold;
	endproperty
	a_warn: assert property (p_warn) else $error("warn action wrong");

	property p_hold;
		@(posedge i_mclk) disable iff (!i_rst_n)
		$rose(o_freq_hold) |-> o_held_freq == $past(i_pid_freq) && o_feedback_loss_warning;
	endproperty
	a_hold: assert property (p_hold) else $error("held frequency wrong");

	property p_sleep_off;
		@(posedge i_mclk) disable iff (!i_rst_n)
		!sleep_en |=> !o_sleep_decel && !o_sleeping;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("sleep while disabled");

	property p_block_zero;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(state == PFS_DECEL && i_out_zero && sleep_en && !tmr_done[2])
			|=> o_sleeping && o_output_block && !o_sleep_decel;
	endproperty
	a_block_zero: assert property (p_block_zero) else $error("no block at zero");

	property p_unarmed;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(state == PFS_AWAKE && !armed) |=> !o_sleep_decel;
	endproperty
	a_unarmed: assert property (p_unarmed) else $error("sleep before arming");

	property p_restart;
		@(posedge i_mclk) disable iff (!i_rst_n)
		!loss_cond ##1 loss_cond |-> tmr_cnt[0] == 16'h0000 && !o_feedback_loss_warning;
	endproperty
	a_restart: assert property (p_restart) else $error("loss timer kept count");

endmodule

// *** verification/pfs_process_model.sv ***
`timescale 1ns/1ps
// Stand-in for the feedback sensor, the PID regulator and the drive's ramp to zero
module pfs_process_model #(
	parameter int RAMP = 6
) (
	input  wire logic               i_mclk,
	input  wire logic               i_stop,
	input  wire pfs_pkg::pfs_word_t i_fb_set,
	input  wire pfs_pkg::pfs_word_t i_freq_set,
	output pfs_pkg::pfs_word_t      o_feedback,
	output pfs_pkg::pfs_word_t      o_pid_freq,
	output logic                    o_out_zero
);
	import pfs_pkg::*;

	int ramp_left;

	// Sensor and regulator register their values; the ramp runs down only while stopping
	always @(posedge i_mclk) begin
		o_feedback <= i_fb_set;
		o_pid_freq <= i_freq_set;
		ramp_left  <= i_stop ? ((ramp_left > 0) ? ramp_left - 1 : 0) : RAMP;
		o_out_zero <= i_stop && (ramp_left == 0);
	end
endmodule

// *** verification/tb_pid_feedback_loss_and_sleep_supervisor.sv ***
`timescale 1ns/1ps
`include "pfs_regs.svh"
module tb_pid_feedback_loss_and_sleep_supervisor;
	import pfs_pkg::*;
	localparam int TK = 10;
	localparam int BLK = 0, DEC = 1, SLP = 2, FLT = 3, WRN = 4, HLD = 5;
	logic        mclk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic [15:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        running, pid_src, neg_char;
	pfs_word_t   fb_set, freq_set, setpoint, max_freq, feedback, pid_freq, held;
	wire         awready, wready, bvalid, arready, rvalid, out_zero;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	wire [5:0]   outs;
	int          failures, n_compared;
	int          dflt[9]   = '{0, 10, 1000, 0, 0, 1000, 600, 50, 10};
	int          mx[9]     = '{3, 1200, 1000, 1000, 1, 5000, 36000, 500, 600};
	int          st_exp[4] = '{0, 1, 2, 6};
	int          shadow[9];

	pfs_supervisor #(.AW(16), .TICK_CYCLES(TK)) i_dut (
		.i_mclk(mclk), .i_rst_n(rst_n), .i_awvalid(awvalid), .o_awready(awready),
		.i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
		.i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
		.i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
		.i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_running(running),
		.i_pid_source(pid_src), .i_negative_char(neg_char), .i_feedback(feedback),
		.i_setpoint(setpoint), .i_pid_freq(pid_freq), .i_maximum_output_frequency(max_freq),
		.i_out_zero(out_zero), .o_output_block(outs[BLK]), .o_sleep_decel(outs[DEC]),
		.o_sleeping(outs[SLP]), .o_feedback_loss_fault(outs[FLT]),
		.o_feedback_loss_warning(outs[WRN]), .o_freq_hold(outs[HLD]), .o_held_freq(held));

	pfs_process_model i_proc (
		.i_mclk(mclk), .i_stop(outs[DEC] | outs[BLK]), .i_fb_set(fb_set),
		.i_freq_set(freq_set), .o_feedback(feedback), .o_pid_freq(pid_freq),
		.o_out_zero(out_zero));

	// Clock at 20 MHz
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// Compare and count
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic stop_test();
		if (failures == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Register write; each channel is held until its own ready
	task automatic wr(logic [15:0] a, logic [31:0] d, logic [3:0] s, output logic [1:0] r);
		bit aw_p, w_p;
		aw_p = 1;
		w_p = 1;
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (aw_p || w_p) begin
			@(posedge mclk);
			if (aw_p && awready === 1'b1) begin
				aw_p = 0;
				awvalid <= 1'b0;
			end
			if (w_p && wready === 1'b1) begin
				w_p = 0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge mclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge mclk);
	endtask

	// Register read
	task automatic rd(logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge mclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge mclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge mclk);
	endtask

	function automatic logic [15:0] ra(int i);
		return {`PFS_IDX_LOSS_ACT + 14'(i), 2'b00};
	endfunction

	// Write a setting, expecting an OKAY answer; the shadow keeps only in-range values
	task automatic setr(int i, int v);
		logic [1:0] r;
		wr(ra(i), 32'(v), 4'hF, r);
		chk("bresp", 0, r);
		if (v <= ((i == 5) ? int'(max_freq) : mx[i])) begin
			shadow[i] = v;
		end
	endtask

	// Read a register and compare data and response
	task automatic getr(string nm, logic [15:0] a, int v, logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(nm, v, d);
		chk("rresp", er, r);
	endtask

	// Output must not show before lo cycles and must show within hi more
	task automatic wait_out(string nm, int o, logic v, int lo, int hi);
		int t;
		t = 0;
		repeat (lo) @(posedge mclk);
		if (lo > 0) chk(nm, !v, outs[o]);
		while (outs[o] !== v && t < hi) begin
			@(posedge mclk);
			t++;
		end
		chk(nm, v, outs[o]);
	endtask

	// Cuts a hang short
	initial begin
		repeat (40000) @(posedge mclk);
		failures++;
		stop_test();
	end

	initial begin
		logic [1:0] r;
		int         v;
		int         rf;
		rst_n    <= 1'b0;
		awvalid  <= 1'b0;
		wvalid   <= 1'b0;
		bready   <= 1'b0;
		arvalid  <= 1'b0;
		rready   <= 1'b0;
		awaddr   <= 16'h0000;
		araddr   <= 16'h0000;
		wdata    <= 32'h0000_0000;
		wstrb    <= 4'h0;
		running  <= 1'b1;
		pid_src  <= 1'b1;
		neg_char <= 1'b0;
		fb_set   <= 16'h01F4;
		setpoint <= 16'h01F4;
		freq_set <= 16'h07D0;
		max_freq <= 16'h1388;
		void'($urandom(32'h9d2e));
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		shadow = dflt;
		// Reset values, then legal, too large and half-strobed writes
		for (int i = 0; i < 9; i++)
			getr("dflt", ra(i), dflt[i], 0);
		getr("status", ra(9), 0, 0);
		for (int i = 0; i < 9; i++) begin
			v = $urandom_range(mx[i], 0);
			setr(i, v);
			setr(i, mx[i] + 1);
			wr(ra(i), (v == 0) ? 1 : 0, 4'h1, r);
			getr("range", ra(i), shadow[i], 0);
		end
		wr(16'h0000, 32'h0000_0001, 4'hF, r);
		chk("bresp unmapped", `PFS_RESP_SLVERR, r);
		getr("unmapped", ra(10), 0, `PFS_RESP_SLVERR);
		// The sleep frequency bound follows the live maximum frequency
		rf = $urandom_range(4000, 1000);
		max_freq <= pfs_word_t'(rf);
		@(posedge mclk);
		setr(5, rf + 1);
		getr("fmax over", ra(5), shadow[5], 0);
		setr(5, rf);
		getr("fmax top", ra(5), rf, 0);
		// Loss on both limits, just outside them, under every action
		setr(0, 0);
		setr(4, 0);
		setr(1, 3);
		setr(2, 800);
		setr(3, 200);
		wr(ra(9), 32'h0000_0001, 4'hF, r);
		for (int a = 0; a < 4; a++) begin
			for (int u = 0; u < 2; u++) begin
				rf = $urandom_range(4000, 100);
				freq_set <= pfs_word_t'(rf);
				setr(0, a);
				fb_set <= u ? 16'h0321 : 16'h00C7;
				if (a == 0) begin
					repeat (60) @(posedge mclk);
					chk("no detect", 0, outs);
				end else begin
					wait_out("detect", a == 1 ? FLT : a == 2 ? WRN : HLD, 1, 18, 22);
				end
				chk("block", a == 1, outs[BLK]);
				chk("warn", a >= 2, outs[WRN]);
				chk("hold", a == 3, outs[HLD]);
				getr("status", ra(9), st_exp[a], 0);
				freq_set <= pfs_word_t'(rf + 7);
				repeat (4) @(posedge mclk);
				chk("held", a == 3 ? rf : rf + 7, held);
				fb_set <= 16'h01F4;
				repeat (4) @(posedge mclk);
				chk("after", a == 1 ? 6'h09 : 6'h00, outs);
				wr(ra(9), 32'h0000_0001, 4'hF, r);
				chk("cleared", 0, outs);
			end
		end
		// No detection unless running with PID as the source
		setr(0, 2);
		for (int g = 0; g < 2; g++) begin
			running <= (g == 1);
			pid_src <= (g == 0);
			fb_set  <= 16'h0384;
			repeat (60) @(posedge mclk);
			chk("gated", 0, outs[WRN]);
			fb_set <= 16'h01F4;
			repeat (4) @(posedge mclk);
		end
		running <= 1'b1;
		pid_src <= 1'b1;
		// A dropped condition restarts the timer
		fb_set <= 16'h0384;
		repeat (15) @(posedge mclk);
		fb_set <= 16'h01F4;
		repeat (3) @(posedge mclk);
		fb_set <= 16'h0384;
		wait_out("restart", WRN, 1, 18, 22);
		fb_set <= 16'h01F4;
		repeat (4) @(posedge mclk);
		setr(1, 0);
		fb_set <= 16'h0384;
		wait_out("zero delay", WRN, 1, 0, 4);
		fb_set <= 16'h01F4;
		repeat (4) @(posedge mclk);
		setr(0, 0);
		// Sleep entry and wake under both characteristics
		setr(5, 1000);
		setr(6, 2);
		setr(7, 50);
		setr(8, 2);
		for (int n = 0; n < 2; n++) begin
			neg_char <= n[0];
			setr(4, 0);
			fb_set   <= n ? 16'h0190 : 16'h0258;
			freq_set <= 16'h01F4;
			repeat (60) @(posedge mclk);
			chk("sleep off", 0, outs[DEC]);
			fb_set <= n ? 16'h0258 : 16'h0190;
			repeat (3) @(posedge mclk);
			setr(4, 1);
			repeat (60) @(posedge mclk);
			chk("unarmed", 0, outs[DEC]);
			freq_set <= 16'h07D0;
			fb_set   <= n ? 16'h0190 : 16'h0258;
			repeat (5) @(posedge mclk);
			fb_set   <= 16'h01F4;
			freq_set <= 16'h01F4;
			wait_out("decel", DEC, 1, 8, 20);
			wait_out("asleep", SLP, 1, 0, 15);
			chk("asleep outs", 6'h05, outs);
			fb_set <= n ? 16'h0226 : 16'h01C2;
			repeat (40) @(posedge mclk);
			chk("edge", 1, outs[SLP]);
			fb_set <= n ? 16'h0227 : 16'h01C1;
			wait_out("wake", SLP, 0, 8, 20);
			chk("awake outs", 0, outs);
		end
		// Wake during deceleration, then disable while asleep
		setr(8, 0);
		for (int k = 0; k < 2; k++) begin
			freq_set <= 16'h07D0;
			fb_set   <= 16'h0190;
			repeat (5) @(posedge mclk);
			fb_set   <= 16'h01F4;
			freq_set <= 16'h01F4;
			wait_out("decel again", DEC, 1, 8, 20);
			if (k == 0) begin
				fb_set <= 16'h0227;
				wait_out("wake in decel", DEC, 0, 0, 4);
				chk("never asleep", 0, outs[SLP]);
			end else begin
				wait_out("asleep again", SLP, 1, 0, 15);
				setr(4, 0);
				chk("disabled outs", 0, outs);
			end
		end
		for (int i = 0; i < 9; i++)
			getr("final", ra(i), shadow[i], 0);
		stop_test();
	end
endmodule
